// ===== core/wdt_watchdog.sv
// Watchdog timer top: wishbone registers, strap, counter and reset pulses
//
// Function
// [RULE_01] 8-bit counter enabled by 11-bit prescaler
// [RULE_02] Prescaler ticks at oscillator over twelve
// [RULE_03] Counter advances every 2048 machine cycles
// [RULE_04] Overflow raises short internal chip reset
// [RULE_05] Overflow pulls reset pin three machine cycles
// [RULE_06] Strap low keeps watchdog on, no override
// [RULE_07] Strap high disables watchdog entirely
// [RULE_08] Counter writes need unlock flag set
// [RULE_09] Successful load clears unlock flag
// [RULE_10] Software sets unlock, then writes counter
// [RULE_11] Software reloads before interval runs out
// [RULE_12] Counts up from loaded value
// [RULE_13] Keeps running in idle mode
// [RULE_14] Power-down bit held zero while enabled
// [RULE_15] Overflow is ff to 00; reload restarts
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
module wdt_watchdog
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire wdt_wbreq_s wbReq,
  output logic [WB_DW-1:0] wbDatO,
  output logic wbAck,
  input wire logic watchdogStrapN,
  output logic sysResetQ,
  output logic rstPinOeN,
  output logic idleQ,
  output logic powerDownQ,
  output logic [7:0] watchdogCountQ
);

  // Match a word address against a register index
  function automatic logic hitReg(input logic [WB_AW-1:0] adr, input logic [7:0] idx);
    hitReg = (adr[WB_AW-1:2] == idx) && (adr[1:0] == 2'b00);
  endfunction

  logic rstMetaQ;
  logic rstSyncQ;
  logic rstN;
  logic strapMetaQ;
  logic strapSyncQ;
  logic enabled;
  logic [7:0] powerControlQ;
  logic reloadUnlockFlag;
  logic mcTick;
  logic wrapTick;
  logic wrStrobe;
  logic wrPowerControl;
  logic wrCount;
  logic loadCount;
  logic overflow;
  logic [5:0] sysCntQ;
  logic [5:0] pinCntQ;

  // Reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMetaQ <= 1'b0;
      rstSyncQ <= 1'b0;
    end else begin
      rstMetaQ <= 1'b1;
      rstSyncQ <= rstMetaQ;
    end
  end

  assign rstN = rstSyncQ;

  // Strap pin synchroniser; idles at disabled
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      strapMetaQ <= 1'b1;
      strapSyncQ <= 1'b1;
    end else begin
      strapMetaQ <= watchdogStrapN;
      strapSyncQ <= strapMetaQ;
    end
  end

  // Enable follows the strap only; no register can override it
  // [RULE_06] [RULE_07] strap decides enable
  assign enabled = !strapSyncQ;

  // Bus write strobes, effective on the acknowledged edge
  assign wrStrobe = wbReq.cyc && wbReq.stb && wbReq.we && wbAck && wbReq.sel[0];
  assign wrPowerControl = wrStrobe && hitReg(wbReq.adr, IDX_POWER_CONTROL);
  assign wrCount = wrStrobe && hitReg(wbReq.adr, IDX_WATCHDOG_COUNT);

  // A counter write only lands while unlocked
  // [RULE_08] gated load
  assign loadCount = wrCount && reloadUnlockFlag;

  assign reloadUnlockFlag = powerControlQ[PC_UNLOCK_BIT];

  // Wrap from ff on a tick, masked by a reload in the same cycle
  // [RULE_15] overflow detect
  assign overflow = enabled && wrapTick && !loadCount && (watchdogCountQ == COUNT_LAST);

  // Machine-cycle divider and prescaler; prescaler cleared when off or reloaded, divider free-running
  wdt_prescaler u_pre (
    .clk(clk),
    .rstN(rstN),
    .clear(!enabled || loadCount),
    .mcTick(mcTick),
    .wrapTick(wrapTick)
  );

  // Wishbone acknowledge; one cycle per request, low between requests
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wbAck <= 1'b0;
    end else begin
      wbAck <= wbReq.cyc && wbReq.stb && !wbAck;
    end
  end

  // Read data captured with the acknowledge; unmapped reads give zero
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wbDatO <= RDAT_RESET;
    end else if (wbReq.cyc && wbReq.stb && !wbAck) begin
      if (hitReg(wbReq.adr, IDX_POWER_CONTROL)) begin
        wbDatO <= {24'h000000, powerControlQ};
      end else if (hitReg(wbReq.adr, IDX_WATCHDOG_COUNT)) begin
        wbDatO <= {24'h000000, watchdogCountQ};
      end else begin
        wbDatO <= RDAT_RESET;
      end
    end else begin
      wbDatO <= RDAT_RESET;
    end
  end

  // Power control register; a watchdog reset clears it
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      powerControlQ <= PC_RESET;
    end else if (overflow) begin
      powerControlQ <= PC_RESET;
    end else begin
      if (wrPowerControl) begin
        powerControlQ <= wbReq.dat[7:0];
      end
      // [RULE_09] clear unlock on load
      if (loadCount) begin
        powerControlQ[PC_UNLOCK_BIT] <= 1'b0;
      end
      // [RULE_14] block power-down
      if (enabled) begin
        powerControlQ[PC_PDOWN_BIT] <= 1'b0;
      end
    end
  end

  assign idleQ = powerControlQ[PC_IDLE_BIT];
  assign powerDownQ = powerControlQ[PC_PDOWN_BIT];

  // Watchdog counter; idle has no effect on it
  // [RULE_12] [RULE_13] up count from reload
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      watchdogCountQ <= COUNT_RESET;
    end else if (loadCount) begin
      watchdogCountQ <= wbReq.dat[7:0];
    end else if (enabled && wrapTick) begin
      watchdogCountQ <= watchdogCountQ + 8'h01;
    end
  end

  // Internal chip reset pulse of one machine cycle
  // [RULE_04] internal reset pulse
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sysCntQ <= 6'h00;
      sysResetQ <= 1'b0;
    end else if (overflow) begin
      sysCntQ <= SYS_PULSE_CLKS - 6'h01;
      sysResetQ <= 1'b1;
    end else if (sysCntQ != 6'h00) begin
      sysCntQ <= sysCntQ - 6'h01;
      sysResetQ <= 1'b1;
    end else begin
      sysResetQ <= 1'b0;
    end
  end

  // Open-drain reset pin pulled low for three machine cycles
  // [RULE_05] pin reset pulse
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinCntQ <= 6'h00;
      rstPinOeN <= 1'b1;
    end else if (overflow) begin
      pinCntQ <= PIN_PULSE_CLKS - 6'h01;
      rstPinOeN <= 1'b0;
    end else if (pinCntQ != 6'h00) begin
      pinCntQ <= pinCntQ - 6'h01;
      rstPinOeN <= 1'b0;
    end else begin
      rstPinOeN <= 1'b1;
    end
  end

  property p_load;
    @(posedge clk) disable iff (!rstN)
    (wrCount && reloadUnlockFlag) |=> (watchdogCountQ == $past(wbReq.dat[7:0]));
  endproperty
  a_load: assert property (p_load) else $error("unlocked reload did not land"); // [RULE_08]

  property p_locked;
    @(posedge clk) disable iff (!rstN)
    (wrCount && !reloadUnlockFlag && !(enabled && wrapTick)) |=> $stable(watchdogCountQ);
  endproperty
  a_locked: assert property (p_locked) else $error("locked write changed counter"); // [RULE_08]

  property p_unlock_clear;
    @(posedge clk) disable iff (!rstN)
    loadCount |=> !reloadUnlockFlag;
  endproperty
  a_unlock_clear: assert property (p_unlock_clear) else $error("unlock flag kept"); // [RULE_09]

  property p_no_pdown;
    @(posedge clk) disable iff (!rstN)
    enabled ##1 enabled |-> !powerDownQ;
  endproperty
  a_no_pdown: assert property (p_no_pdown) else $error("power-down set while enabled"); // [RULE_14]

  property p_disabled;
    @(posedge clk) disable iff (!rstN)
    (!enabled && !sysResetQ && rstPinOeN) |=> (!sysResetQ && rstPinOeN);
  endproperty
  a_disabled: assert property (p_disabled) else $error("reset while disabled"); // [RULE_07]

  property p_sys_pulse;
    @(posedge clk) disable iff (!rstN)
    $rose(sysResetQ) |-> ##11 sysResetQ ##1 !sysResetQ;
  endproperty
  a_sys_pulse: assert property (p_sys_pulse) else $error("internal reset length wrong"); // [RULE_04]

  property p_pin_pulse;
    @(posedge clk) disable iff (!rstN)
    $fell(rstPinOeN) |-> ##35 !rstPinOeN ##1 rstPinOeN;
  endproperty
  a_pin_pulse: assert property (p_pin_pulse) else $error("pin reset length wrong"); // [RULE_05]

  property p_wrap;
    @(posedge clk) disable iff (!rstN)
    overflow |=> (watchdogCountQ == 8'h00) && sysResetQ && !rstPinOeN;
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow handling wrong"); // [RULE_15]

  property p_step;
    @(posedge clk) disable iff (!rstN)
    (enabled && wrapTick && !loadCount) |=> (watchdogCountQ == $past(watchdogCountQ) + 8'h01);
  endproperty
  a_step: assert property (p_step) else $error("counter did not step"); // [RULE_12]

  property p_idle_runs;
    @(posedge clk) disable iff (!rstN)
    (idleQ && enabled && !loadCount && !wrapTick) |=> $stable(watchdogCountQ);
  endproperty
  a_idle_runs: assert property (p_idle_runs) else $error("counter moved off tick"); // [RULE_13]

  property p_enable_strap;
    @(posedge clk) disable iff (!rstN)
    $fell(watchdogStrapN) |-> ##2 enabled;
  endproperty
  a_enable_strap: assert property (p_enable_strap) else $error("strap low not enabling"); // [RULE_06]

  property p_hold;
    @(posedge clk) disable iff (!rstN)
    (!loadCount && !(enabled && wrapTick)) |=> $stable(watchdogCountQ);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved off tick"); // [RULE_03]

  property p_held;
    @(posedge clk) disable iff (!rstN)
    !enabled |=> !wrapTick;
  endproperty
  a_held: assert property (p_held) else $error("prescaler ran while off"); // [RULE_07]

  property p_pin_sys;
    @(posedge clk) disable iff (!rstN)
    $rose(sysResetQ) |-> !rstPinOeN;
  endproperty
  a_pin_sys: assert property (p_pin_sys) else $error("pin pulse missing"); // [RULE_05]

  property p_pd_write;
    @(posedge clk) disable iff (!rstN)
    (wrPowerControl && enabled) |=> !powerDownQ;
  endproperty
  a_pd_write: assert property (p_pd_write) else $error("power-down set"); // [RULE_14]

  property p_wrap_zero;
    @(posedge clk) disable iff (!rstN)
    $rose(sysResetQ) |-> (watchdogCountQ == 8'h00);
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("reset without wrap"); // [RULE_15]

endmodule

// ===== core/wdt_pkg.sv
// Package with register map, bus carrier and timing constants of the watchdog
package wdt_pkg;

  // Bus geometry
  localparam int WB_AW = 10;
  localparam int WB_DW = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_WATCHDOG_COUNT = 8'hff;

  // Power control field positions
  localparam int PC_IDLE_BIT = 0;
  localparam int PC_PDOWN_BIT = 1;
  localparam int PC_UNLOCK_BIT = 4;

  // Values after reset
  localparam logic [7:0] PC_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [WB_DW-1:0] RDAT_RESET = 32'h00000000;

  // Oscillator clocks per machine cycle
  localparam int MC_CLKS = 12;
  localparam logic [3:0] MC_LAST = 4'hb;
  // Prescaler width and its terminal value
  localparam int PRE_W = 11;
  localparam logic [PRE_W-1:0] PRE_LAST = 11'h7ff;
  // Counter terminal value
  localparam logic [7:0] COUNT_LAST = 8'hff;
  // Internal reset length in machine cycles and in clocks
  localparam int SYS_PULSE_MC = 1;
  localparam logic [5:0] SYS_PULSE_CLKS = 6'(SYS_PULSE_MC * MC_CLKS);
  // Reset pin pulse length in machine cycles and in clocks
  localparam int PIN_PULSE_MC = 3;
  localparam logic [5:0] PIN_PULSE_CLKS = 6'(PIN_PULSE_MC * MC_CLKS);

  // Classic wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [WB_AW-1:0] adr;
    logic [3:0] sel;
    logic [WB_DW-1:0] dat;
  } wdt_wbreq_s;

endpackage

// ===== core/wdt_prescaler.sv
// Machine-cycle divider and 11-bit prescaler feeding the watchdog counter
`timescale 1ns/1ns
module wdt_prescaler
  import wdt_pkg::*;
(
  input wire logic clk,
  input wire logic rstN,
  input wire logic clear,
  output logic mcTick,
  output logic wrapTick
);

  logic [3:0] divQ;
  logic [PRE_W-1:0] preQ;

  // Divide the oscillator by twelve
  // [RULE_02] machine cycle tick
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      divQ <= 4'h0;
      mcTick <= 1'b0;
    end else begin
      mcTick <= (divQ == MC_LAST);
      divQ <= (divQ == MC_LAST) ? 4'h0 : divQ + 4'h1;
    end
  end

  // Prescaler stage; wraps once per 2048 machine cycles
  // [RULE_01] [RULE_03] prescaler wrap tick
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      preQ <= '0;
      wrapTick <= 1'b0;
    end else if (clear) begin
      preQ <= '0;
      wrapTick <= 1'b0;
    end else begin
      wrapTick <= mcTick && (preQ == PRE_LAST);
      if (mcTick) begin
        preQ <= preQ + 11'h001;
      end
    end
  end

  property p_mc_period;
    @(posedge clk) disable iff (!rstN)
    mcTick |-> ##12 mcTick;
  endproperty
  a_mc_period: assert property (p_mc_period) else $error("machine tick period wrong"); // [RULE_02]

  property p_wrap_rare;
    @(posedge clk) disable iff (!rstN || clear)
    wrapTick |=> !wrapTick ##1 !wrapTick;
  endproperty
  a_wrap_rare: assert property (p_wrap_rare) else $error("prescaler wrapped too often"); // [RULE_03]

endmodule

// ===== bench/wdt_watchdog_tb.sv
// Self-checking testbench for the watchdog timer top
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module wdt_watchdog_tb;
  import wdt_pkg::*;
  localparam logic [9:0] ADR_PC = {IDX_POWER_CONTROL, 2'b00};
  localparam logic [9:0] ADR_CNT = {IDX_WATCHDOG_COUNT, 2'b00};
  localparam logic [9:0] ADR_NONE = 10'h100;
  // Clocks between two counter steps
  localparam int IVL = (1 << PRE_W) * MC_CLKS;
  logic clk;
  logic reset_n;
  wdt_wbreq_s wbReq;
  logic [WB_DW-1:0] wbDatO;
  logic wbAck;
  logic watchdogStrapN;
  logic sysResetQ;
  logic rstPinOeN;
  logic idleQ;
  logic powerDownQ;
  logic [7:0] watchdogCountQ;
  int miscompares;
  int cmp_count;
  logic [31:0] rdData;
  int n;
  int sysLen;
  int pinLen;

  wdt_watchdog DUT (
    .clk(clk),
    .reset_n(reset_n),
    .wbReq(wbReq),
    .wbDatO(wbDatO),
    .wbAck(wbAck),
    .watchdogStrapN(watchdogStrapN),
    .sysResetQ(sysResetQ),
    .rstPinOeN(rstPinOeN),
    .idleQ(idleQ),
    .powerDownQ(powerDownQ),
    .watchdogCountQ(watchdogCountQ)
  );

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Verdict and end of run
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One classic wishbone cycle; holds the request until ack is sampled
  task automatic bus(input logic we, input logic [9:0] adr, input logic [7:0] dat,
                     output logic [31:0] rd);
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: {24'h0, dat}};
    @(posedge clk);
    while (wbAck !== 1'b1) begin
      @(posedge clk);
    end
    rd = wbDatO;
    wbReq <= '0;
  endtask

  task automatic wr(input logic [9:0] adr, input logic [7:0] dat);
    logic [31:0] dummy;
    bus(1'b1, adr, dat, dummy);
  endtask

  task automatic rd_chk(input string nm, input logic [9:0] adr, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, adr, 8'h00, got);
    `CHK(nm, exp, got)
  endtask

  // Hang guard, sized above the two watchdog intervals and the frozen span
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    close_out();
  end

  // Main sequence
  initial begin
    reset_n <= 1'b0;
    wbReq <= '0;
    watchdogStrapN <= 1'b0;
    miscompares = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk("pc_reset", ADR_PC, 32'h00000000);
    rd_chk("cnt_reset", ADR_CNT, 32'h00000000);
    wr(ADR_CNT, 8'h55);
    rd_chk("cnt_locked", ADR_CNT, 32'h00000000);
    wr(ADR_PC, 8'h12);
    rd_chk("pc_pdown", ADR_PC, 32'h00000010);
    `CHK("pdown_pin", 1'b0, powerDownQ)
    wr(ADR_CNT, 8'hfe);
    rd_chk("cnt_load", ADR_CNT, 32'h000000fe);
    rd_chk("pc_unlock_clr", ADR_PC, 32'h00000000);
    rd_chk("unmapped", ADR_NONE, 32'h00000000);
    // idle set, reload restarts a full interval
    wr(ADR_PC, 8'h11);
    wr(ADR_CNT, 8'hfe);
    @(negedge clk);
    `CHK("idle_pin", 1'b1, idleQ)
    n = 0;
    while (watchdogCountQ === 8'hfe && n < 26000) begin
      n++;
      @(negedge clk);
    end
    // Reload may land anywhere in the free-running machine cycle
    `CHK("interval_ok", 1'b1, (n >= IVL - MC_CLKS + 2 && n <= IVL + 1))
    `CHK("cnt_step", 8'hff, watchdogCountQ)
    `CHK("sys_quiet", 1'b0, sysResetQ)
    n = 0;
    while (sysResetQ !== 1'b1 && n < 26000) begin
      n++;
      @(negedge clk);
    end
    `CHK("wrap_time", IVL, n)
    `CHK("cnt_wrap", 8'h00, watchdogCountQ)
    `CHK("pin_start", 1'b0, rstPinOeN)
    sysLen = 0;
    pinLen = 0;
    repeat (45) begin
      if (sysResetQ === 1'b1) sysLen++;
      if (rstPinOeN === 1'b0) pinLen++;
      @(negedge clk);
    end
    `CHK("sys_len", 12, sysLen)
    `CHK("pin_len", 36, pinLen)
    `CHK("idle_cleared", 1'b0, idleQ)
    // strap high freezes counter and allows power-down
    wr(ADR_PC, 8'h10);
    wr(ADR_CNT, 8'hff);
    watchdogStrapN <= 1'b1;
    repeat (4) @(posedge clk);
    wr(ADR_PC, 8'h02);
    @(negedge clk);
    `CHK("pdown_off", 1'b1, powerDownQ)
    sysLen = 0;
    repeat (26000) begin
      @(negedge clk);
      if (sysResetQ !== 1'b0 || rstPinOeN !== 1'b1) sysLen++;
    end
    `CHK("no_reset", 0, sysLen)
    rd_chk("cnt_frozen", ADR_CNT, 32'h000000ff);
    // strap low again re-arms and drops power-down
    watchdogStrapN <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK("pdown_rearm", 1'b0, powerDownQ)
    rd_chk("pc_rearm", ADR_PC, 32'h00000000);
    close_out();
  end
endmodule
